// file: core/sflo_defs.svh
`ifndef SFLO_DEFS_SVH
`define SFLO_DEFS_SVH

`define SFLO_OFF_STATUS 12'h000
`define SFLO_OFF_SP 12'h004
`define SFLO_OFF_CTRL 12'h008
`define SFLO_OFF_STATE 12'h00C
`define SFLO_OFF_REGSEL 12'h010
`define SFLO_OFF_REGDATA 12'h014

`define SFLO_RST_STATUS 8'h00
`define SFLO_RST_SP 16'h01FF
`define SFLO_RST_CTRL 1'b1

`define SFLO_FLAG_C 0
`define SFLO_FLAG_Z 1
`define SFLO_FLAG_N 2
`define SFLO_FLAG_V 3
`define SFLO_FLAG_S 4
`define SFLO_FLAG_H 5
`define SFLO_FLAG_T 6
`define SFLO_FLAG_I 7

`define SFLO_PTR_X 5'h1A
`define SFLO_PTR_Y 5'h1C
`define SFLO_PTR_Z 5'h1E

`define SFLO_CYC_MEM 2
`define SFLO_CYC_PROG 3

`endif

// file: core/sflo_pkg.sv
package sflo_pkg;

    typedef enum logic [4:0] {
        SFLO_OP_NOP, SFLO_OP_LOGICAL_RIGHT_SHIFT, SFLO_OP_ROTATE_LEFT_CARRY, SFLO_OP_ROTATE_RIGHT_CARRY,
        SFLO_OP_ARITH_RIGHT_SHIFT, SFLO_OP_SWAP, SFLO_OP_FLAG_SET, SFLO_OP_FLAG_CLEAR,
        SFLO_OP_BIT_TO_TRANSFER_FLAG, SFLO_OP_TRANSFER_FLAG_TO_BIT, SFLO_OP_MOVE, SFLO_OP_REGISTER_PAIR_COPY,
        SFLO_OP_LOAD_IMM, SFLO_OP_INDIRECT_LOAD, SFLO_OP_INDIRECT_STORE, SFLO_OP_DIRECT_LOAD,
        SFLO_OP_DIRECT_STORE, SFLO_OP_PROGRAM_MEM_READ, SFLO_OP_PUSH, SFLO_OP_POP, SFLO_OP_PORT_IN,
        SFLO_OP_PORT_OUT, SFLO_OP_SLEEP, SFLO_OP_WATCHDOG_RESTART, SFLO_OP_BREAK
    } sflo_op_t;

    typedef enum logic [1:0] {
        SFLO_PTR_SEL_X = 2'h0,
        SFLO_PTR_SEL_Y = 2'h1,
        SFLO_PTR_SEL_Z = 2'h2
    } sflo_ptr_t;

    typedef enum logic [1:0] {
        SFLO_AM_PLAIN = 2'h0,
        SFLO_AM_POST_INC = 2'h1,
        SFLO_AM_PRE_DEC = 2'h2,
        SFLO_AM_DISP = 2'h3
    } sflo_amode_t;

    typedef enum logic [2:0] {
        SFLO_ST_IDLE = 3'b001,
        SFLO_ST_MEM = 3'b010,
        SFLO_ST_PROG = 3'b100
    } sflo_state_t;

    typedef struct packed {
        sflo_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [2:0] bitSel;
        sflo_ptr_t ptr;
        sflo_amode_t mode;
        logic [5:0] disp;
        logic [15:0] addr;
        logic [5:0] ioAddr;
    } sflo_cmd_t;

    typedef struct packed {
        logic [31:0][7:0] gpr;
        logic [7:0] status_flags_reg;
        logic [15:0] sp;
        logic ctrlEn;
        logic [4:0] regSel;
        sflo_state_t fsm;
        logic progLeft;
        sflo_cmd_t cmd;
        logic [15:0] memAddr;
        logic [7:0] memWdata;
        logic memWe;
        logic memRe;
        logic [15:0] progAddr;
        logic progRe;
        logic [5:0] ioWrAddr;
        logic [7:0] ioWdata;
        logic ioWe;
        logic sleepReq;
        logic wdtRestart;
        logic dbgBreak;
        logic done;
        logic [31:0] prdata;
        logic pslverr;
    } sflo_st_t;

endpackage

// file: core/sflo_exec.sv
// Functional notes
// - Logical right shift, zero in, flags, one cycle
// - Rotate left through carry, flags, one cycle
// - Rotate right through carry, flags, one cycle
// - Arithmetic right shift keeps top bit
// - Copy register bit into transfer flag
// - Transfer flag into register bit, flags kept
// - Set or clear overflow flag alone
// - Set or clear signed flag alone
// - Set or clear half carry alone
// - Post-increment load, two cycles, no flags
// - Pre-decrement pointer then load, two cycles
// - Displacement load, pointer unchanged, two cycles
// - Post-increment store, two cycles
// - Pre-decrement pointer then store, two cycles
// - Displacement store, pointer unchanged, two cycles
// - Direct load and store, two cycles
// - Program memory read via Z, three cycles
// - Push and pop, two cycles each
// - Sleep issues in one cycle, requests sleep
// - Watchdog restart pulse, one cycle, no flags
// - Break only signals the debug system
`include "sflo_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sflo_exec
    import sflo_pkg::*;
#(
    parameter logic [15:0] SP_RESET = `SFLO_RST_SP
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic opValid,
    input wire sflo_cmd_t opCmd,
    output logic opReady,
    output logic opDone,
    output logic [15:0] memAddr,
    output logic [7:0] memWdata,
    output logic memWe,
    output logic memRe,
    input wire logic [7:0] memRdata,
    output logic [15:0] progAddr,
    output logic progRe,
    input wire logic [7:0] progRdata,
    output logic [5:0] ioRdAddr,
    output logic ioRe,
    input wire logic [7:0] ioRdata,
    output logic [5:0] ioWrAddr,
    output logic [7:0] ioWdata,
    output logic ioWe,
    output logic sleepReq,
    output logic wdtRestart,
    output logic dbgBreak,
    output logic [7:0] statusFlags
);

    logic [1:0] rstSync_reg;
    logic rstLocal_n;
    sflo_st_t s_reg;
    sflo_st_t s_next;
    logic accept;
    logic apbSetup;

    function automatic logic [4:0] ptrBase(input sflo_ptr_t sel);
        if (sel == SFLO_PTR_SEL_X) begin
            ptrBase = `SFLO_PTR_X;
        end else if (sel == SFLO_PTR_SEL_Y) begin
            ptrBase = `SFLO_PTR_Y;
        end else begin
            ptrBase = `SFLO_PTR_Z;
        end
    endfunction

    // Shared flag update of the shift and rotate group
    function automatic logic [7:0] shiftFlags(input logic [7:0] old, input logic [7:0] res, input logic c);
        logic [7:0] f;
        f = old;
        f[`SFLO_FLAG_C] = c;
        f[`SFLO_FLAG_Z] = (res == 8'h00);
        f[`SFLO_FLAG_N] = res[7];
        f[`SFLO_FLAG_V] = res[7] ^ c;
        f[`SFLO_FLAG_S] = c;
        shiftFlags = f;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstLocal_n = rstSync_reg[1];

    // Stalled by the enable bit and by reset; a request taken in reset would be lost
    assign opReady = rstLocal_n && (s_reg.fsm == SFLO_ST_IDLE) && s_reg.ctrlEn;
    assign accept = opValid && opReady;
    assign apbSetup = psel && !penable;

    // Reads of a port complete inside the issuing cycle
    // Port read strobe
    assign ioRe = accept && (opCmd.op == SFLO_OP_PORT_IN);
    assign ioRdAddr = opCmd.ioAddr;

    always_comb begin
        logic [4:0] pb;
        logic [15:0] ptr;
        logic [15:0] eff;
        logic [15:0] upd;
        logic [7:0] src;
        logic [7:0] res;
        pb = ptrBase(opCmd.ptr);
        ptr = {s_reg.gpr[pb + 5'h01], s_reg.gpr[pb]};
        eff = ptr;
        upd = ptr;
        src = s_reg.gpr[opCmd.rd];
        res = 8'h00;
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.memWe = 1'b0;
        s_next.memRe = 1'b0;
        s_next.ioWe = 1'b0;
        s_next.sleepReq = 1'b0;
        s_next.wdtRestart = 1'b0;
        s_next.dbgBreak = 1'b0;
        case (s_reg.fsm)
            SFLO_ST_IDLE: begin
                if (accept) begin
                    s_next.cmd = opCmd;
                    s_next.done = 1'b1;
                    case (opCmd.op)
                        SFLO_OP_LOGICAL_RIGHT_SHIFT: begin
                            res = {1'b0, src[7:1]};
                            s_next.gpr[opCmd.rd] = res;
                            s_next.status_flags_reg = shiftFlags(s_reg.status_flags_reg, res, src[0]);
                        end
                        SFLO_OP_ROTATE_LEFT_CARRY: begin
                            res = {src[6:0], s_reg.status_flags_reg[`SFLO_FLAG_C]};
                            s_next.gpr[opCmd.rd] = res;
                            s_next.status_flags_reg = shiftFlags(s_reg.status_flags_reg, res, src[7]);
                        end
                        SFLO_OP_ROTATE_RIGHT_CARRY: begin
                            res = {s_reg.status_flags_reg[`SFLO_FLAG_C], src[7:1]};
                            s_next.gpr[opCmd.rd] = res;
                            s_next.status_flags_reg = shiftFlags(s_reg.status_flags_reg, res, src[0]);
                        end
                        SFLO_OP_ARITH_RIGHT_SHIFT: begin
                            res = {src[7], src[7:1]};
                            s_next.gpr[opCmd.rd] = res;
                            s_next.status_flags_reg = shiftFlags(s_reg.status_flags_reg, res, src[0]);
                        end
                        SFLO_OP_SWAP: begin
                            s_next.gpr[opCmd.rd] = {src[3:0], src[7:4]};
                        end
                        SFLO_OP_FLAG_SET: begin
                            s_next.status_flags_reg[opCmd.bitSel] = 1'b1;
                        end
                        SFLO_OP_FLAG_CLEAR: begin
                            s_next.status_flags_reg[opCmd.bitSel] = 1'b0;
                        end
                        SFLO_OP_BIT_TO_TRANSFER_FLAG: begin
                            s_next.status_flags_reg[`SFLO_FLAG_T] = s_reg.gpr[opCmd.rr][opCmd.bitSel];
                        end
                        SFLO_OP_TRANSFER_FLAG_TO_BIT: begin
                            s_next.gpr[opCmd.rd][opCmd.bitSel] = s_reg.status_flags_reg[`SFLO_FLAG_T];
                        end
                        SFLO_OP_MOVE: begin
                            s_next.gpr[opCmd.rd] = s_reg.gpr[opCmd.rr];
                        end
                        SFLO_OP_REGISTER_PAIR_COPY: begin
                            s_next.gpr[{opCmd.rd[4:1], 1'b0}] = s_reg.gpr[{opCmd.rr[4:1], 1'b0}];
                            s_next.gpr[{opCmd.rd[4:1], 1'b1}] = s_reg.gpr[{opCmd.rr[4:1], 1'b1}];
                        end
                        SFLO_OP_LOAD_IMM: begin
                            s_next.gpr[opCmd.rd] = opCmd.addr[7:0];
                        end
                        SFLO_OP_INDIRECT_LOAD, SFLO_OP_INDIRECT_STORE: begin
                            if (opCmd.mode == SFLO_AM_POST_INC) begin
                                upd = ptr + 16'h0001;
                            end else if (opCmd.mode == SFLO_AM_PRE_DEC) begin
                                eff = ptr - 16'h0001;
                                upd = eff;
                            end else if (opCmd.mode == SFLO_AM_DISP) begin
                                eff = ptr + {10'h000, opCmd.disp};
                            end
                            s_next.gpr[pb] = upd[7:0];
                            s_next.gpr[pb + 5'h01] = upd[15:8];
                            s_next.memAddr = eff;
                            s_next.memWdata = s_reg.gpr[opCmd.rr];
                            s_next.memWe = (opCmd.op == SFLO_OP_INDIRECT_STORE);
                            s_next.memRe = (opCmd.op == SFLO_OP_INDIRECT_LOAD);
                            s_next.done = 1'b0;
                            s_next.fsm = SFLO_ST_MEM;
                        end
                        SFLO_OP_DIRECT_LOAD, SFLO_OP_DIRECT_STORE: begin
                            s_next.memAddr = opCmd.addr;
                            s_next.memWdata = s_reg.gpr[opCmd.rr];
                            s_next.memWe = (opCmd.op == SFLO_OP_DIRECT_STORE);
                            s_next.memRe = (opCmd.op == SFLO_OP_DIRECT_LOAD);
                            s_next.done = 1'b0;
                            s_next.fsm = SFLO_ST_MEM;
                        end
                        SFLO_OP_PUSH: begin
                            s_next.memAddr = s_reg.sp;
                            s_next.memWdata = s_reg.gpr[opCmd.rr];
                            s_next.memWe = 1'b1;
                            s_next.sp = s_reg.sp - 16'h0001;
                            s_next.done = 1'b0;
                            s_next.fsm = SFLO_ST_MEM;
                        end
                        SFLO_OP_POP: begin
                            s_next.memAddr = s_reg.sp + 16'h0001;
                            s_next.memRe = 1'b1;
                            s_next.sp = s_reg.sp + 16'h0001;
                            s_next.done = 1'b0;
                            s_next.fsm = SFLO_ST_MEM;
                        end
                        SFLO_OP_PROGRAM_MEM_READ: begin
                            s_next.progAddr = {s_reg.gpr[`SFLO_PTR_Z + 5'h01], s_reg.gpr[`SFLO_PTR_Z]};
                            s_next.progRe = 1'b1;
                            s_next.progLeft = 1'b1;
                            if (opCmd.mode == SFLO_AM_POST_INC) begin
                                upd = s_next.progAddr + 16'h0001;
                                s_next.gpr[`SFLO_PTR_Z] = upd[7:0];
                                s_next.gpr[`SFLO_PTR_Z + 5'h01] = upd[15:8];
                            end
                            s_next.done = 1'b0;
                            s_next.fsm = SFLO_ST_PROG;
                        end
                        SFLO_OP_PORT_IN: begin
                            s_next.gpr[opCmd.rd] = ioRdata;
                        end
                        SFLO_OP_PORT_OUT: begin
                            s_next.ioWrAddr = opCmd.ioAddr;
                            s_next.ioWdata = s_reg.gpr[opCmd.rr];
                            s_next.ioWe = 1'b1;
                        end
                        SFLO_OP_SLEEP: begin
                            s_next.sleepReq = 1'b1;
                        end
                        SFLO_OP_WATCHDOG_RESTART: begin
                            s_next.wdtRestart = 1'b1;
                        end
                        SFLO_OP_BREAK: begin
                            s_next.dbgBreak = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            SFLO_ST_MEM: begin
                if (s_reg.memRe) begin
                    s_next.gpr[s_reg.cmd.rd] = memRdata;
                end
                s_next.done = 1'b1;
                s_next.fsm = SFLO_ST_IDLE;
            end
            SFLO_ST_PROG: begin
                // One wait cycle for slow flash
                if (s_reg.progLeft) begin
                    s_next.progLeft = 1'b0;
                end else begin
                    s_next.gpr[s_reg.cmd.rd] = progRdata;
                    s_next.progRe = 1'b0;
                    s_next.done = 1'b1;
                    s_next.fsm = SFLO_ST_IDLE;
                end
            end
            default: begin
                s_next.fsm = SFLO_ST_IDLE;
            end
        endcase
        // Bus writes land after execution, so software wins a same-cycle clash
        if (psel && penable && pwrite) begin
            if (paddr == `SFLO_OFF_STATUS) begin
                s_next.status_flags_reg = pwdata[7:0];
            end else if (paddr == `SFLO_OFF_SP) begin
                s_next.sp = pwdata[15:0];
            end else if (paddr == `SFLO_OFF_CTRL) begin
                s_next.ctrlEn = pwdata[0];
            end else if (paddr == `SFLO_OFF_REGSEL) begin
                s_next.regSel = pwdata[4:0];
            end else if (paddr == `SFLO_OFF_REGDATA) begin
                s_next.gpr[s_reg.regSel] = pwdata[7:0];
            end
        end
        // Read data prepared in setup so the access phase needs no wait
        if (apbSetup) begin
            s_next.pslverr = 1'b0;
            s_next.prdata = 32'h0000_0000;
            if (paddr == `SFLO_OFF_STATUS) begin
                s_next.prdata = {24'h000000, s_reg.status_flags_reg};
            end else if (paddr == `SFLO_OFF_SP) begin
                s_next.prdata = {16'h0000, s_reg.sp};
            end else if (paddr == `SFLO_OFF_CTRL) begin
                s_next.prdata = {31'h0000_0000, s_reg.ctrlEn};
            end else if (paddr == `SFLO_OFF_STATE) begin
                s_next.prdata = {29'h0000_0000, s_reg.fsm};
            end else if (paddr == `SFLO_OFF_REGSEL) begin
                s_next.prdata = {27'h0000_0000, s_reg.regSel};
            end else if (paddr == `SFLO_OFF_REGDATA) begin
                s_next.prdata = {24'h000000, s_reg.gpr[s_reg.regSel]};
            end else begin
                s_next.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            s_reg <= '0;
            s_reg.status_flags_reg <= `SFLO_RST_STATUS;
            s_reg.sp <= SP_RESET;
            s_reg.ctrlEn <= `SFLO_RST_CTRL;
            s_reg.fsm <= SFLO_ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = s_reg.prdata;
    assign pslverr = s_reg.pslverr && psel && penable;
    assign opDone = s_reg.done;
    assign memAddr = s_reg.memAddr;
    assign memWdata = s_reg.memWdata;
    assign memWe = s_reg.memWe;
    assign memRe = s_reg.memRe;
    assign progAddr = s_reg.progAddr;
    assign progRe = s_reg.progRe;
    assign ioWrAddr = s_reg.ioWrAddr;
    assign ioWdata = s_reg.ioWdata;
    assign ioWe = s_reg.ioWe;
    assign sleepReq = s_reg.sleepReq;
    assign wdtRestart = s_reg.wdtRestart;
    assign dbgBreak = s_reg.dbgBreak;
    assign statusFlags = s_reg.status_flags_reg;

endmodule

`default_nettype wire

// file: sim/sflo_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sflo_exec_asserts
    import sflo_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic opValid,
    input wire sflo_cmd_t opCmd,
    input wire logic opReady,
    input wire logic opDone,
    input wire logic memWe,
    input wire logic memRe,
    input wire logic progRe,
    input wire logic sleepReq,
    input wire logic wdtRestart,
    input wire logic ioWe,
    input wire logic dbgBreak,
    input wire logic [7:0] statusFlags
);
    logic acc;
    sflo_op_t o;
    assign acc = opValid && opReady;
    assign o = opCmd.op;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence mem_step;
        !opReady ##1 opDone;
    endsequence
    sequence prog_steps;
        progRe[*2] ##1 (opDone && !progRe);
    endsequence
    a_shift_done: assert property (acc
        && o inside {[SFLO_OP_LOGICAL_RIGHT_SHIFT:SFLO_OP_ARITH_RIGHT_SHIFT]} |=> opDone && !memRe)
        else $error("shift slow");
    a_load_steps: assert property (acc
        && o inside {SFLO_OP_INDIRECT_LOAD, SFLO_OP_DIRECT_LOAD, SFLO_OP_POP} |=> memRe && !memWe ##0 mem_step)
        else $error("load timing");
    a_store_steps: assert property (acc
        && o inside {SFLO_OP_INDIRECT_STORE, SFLO_OP_DIRECT_STORE, SFLO_OP_PUSH} |=> memWe && !memRe ##0 mem_step)
        else $error("store timing");
    a_prog_steps: assert property (acc && o == SFLO_OP_PROGRAM_MEM_READ |=> prog_steps)
        else $error("program read timing");
    a_mem_flags: assert property (acc && o inside {[SFLO_OP_INDIRECT_LOAD:SFLO_OP_POP]}
        |=> $stable(statusFlags)[*2]) else $error("memory op moved flags");
    a_flag_set: assert property (acc && o == SFLO_OP_FLAG_SET
        |=> statusFlags == ($past(statusFlags) | (8'h01 << $past(opCmd.bitSel)))) else $error("flag set");
    a_flag_clear: assert property (acc && o == SFLO_OP_FLAG_CLEAR
        |=> statusFlags == ($past(statusFlags) & ~(8'h01 << $past(opCmd.bitSel)))) else $error("flag clear");
    a_quiet_ops: assert property (acc
        && o inside {SFLO_OP_TRANSFER_FLAG_TO_BIT, SFLO_OP_SWAP, SFLO_OP_REGISTER_PAIR_COPY, SFLO_OP_PORT_IN}
        |=> $stable(statusFlags) && opDone) else $error("flags moved");
    a_wdt_pulse: assert property (acc && o == SFLO_OP_WATCHDOG_RESTART |=> wdtRestart && opDone ##1 !wdtRestart)
        else $error("watchdog pulse");
    a_sleep_req: assert property (acc && o == SFLO_OP_SLEEP |=> sleepReq && opDone)
        else $error("sleep request");
    a_port_write: assert property (acc && o == SFLO_OP_PORT_OUT
        |=> ioWe && opDone && $stable(statusFlags) ##1 !ioWe) else $error("port write pulse");
    a_break_note: assert property (acc && o == SFLO_OP_BREAK
        |=> dbgBreak && $stable(statusFlags)) else $error("break signal");
endmodule
`default_nettype wire

// file: sim/sflo_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sflo_mem_model (
    input wire logic core_clk,
    input wire logic [15:0] memAddr,
    input wire logic [7:0] memWdata,
    input wire logic memWe,
    input wire logic memRe,
    output logic [7:0] memRdata,
    input wire logic [15:0] progAddr,
    input wire logic progRe,
    output logic [7:0] progRdata
);
    // Only 512 bytes, upper address bits ignored
    logic [7:0] dmem [512];
    initial begin
        for (int i = 0; i < 512; i++) begin
            dmem[i] = 8'(i) ^ 8'h5A;
        end
    end
    always @(posedge core_clk) begin
        if (memWe) begin
            dmem[memAddr[8:0]] <= memWdata;
        end
    end
    // Idle reads give inverted data, so a late sample shows
    assign memRdata = memRe ? dmem[memAddr[8:0]] : ~dmem[memAddr[8:0]];
    assign progRdata = (progAddr[7:0] ^ 8'hA5) ^ {8{!progRe}};
endmodule
`default_nettype wire

// file: sim/sflo_exec_bench.sv
`include "sflo_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sflo_exec_bench;
    import sflo_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, opValid = 0, perr;
    logic pready, pslverr, opReady, opDone, memWe, memRe, progRe, ioRe, ioWe, sleepReq, wdtRestart, dbgBreak;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [15:0] memAddr, progAddr;
    logic [7:0] ioRdata = 8'h3C, memWdata, memRdata, progRdata, ioWdata, statusFlags, f;
    logic [5:0] ioRdAddr, ioWrAddr;
    sflo_cmd_t opCmd = '0;
    int err_count = 0, comparisons = 0;
    sflo_op_t so[4] = '{SFLO_OP_LOGICAL_RIGHT_SHIFT, SFLO_OP_ROTATE_RIGHT_CARRY, SFLO_OP_ARITH_RIGHT_SHIFT,
        SFLO_OP_ROTATE_LEFT_CARRY};
    logic [15:0] sx[4] = '{16'h1940, 16'h0CA0, 16'h0CD0, 16'h15A0};
    logic [7:0] ptr[6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h40, 8'h00};
    sflo_exec sflo_exec_i (.*);
    sflo_mem_model sflo_mem_model_i (.*);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #50000;
        err_count++;
        end_of_test();
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setr(input logic [4:0] n, input logic [7:0] v);
        apb(1'b1, `SFLO_OFF_REGSEL, {27'h0, n});
        apb(1'b1, `SFLO_OFF_REGDATA, {24'h0, v});
    endtask
    task automatic getr(input logic [4:0] n, input logic [7:0] e);
        apb(1'b1, `SFLO_OFF_REGSEL, {27'h0, n});
        apb(1'b0, `SFLO_OFF_REGDATA, 32'h0);
        chk(r[7:0], e);
    endtask
    // Bit select rides on the low bits of rd, rr is rd xor ad[15:11]; done is checked n cycles on
    task automatic op(input sflo_op_t o, input logic [4:0] d, input logic [3:0] pm, input logic [15:0] ad,
        input int n);
        @(posedge core_clk);
        opValid <= 1'b1;
        opCmd <= '{o, d, d ^ ad[15:11], d[2:0], sflo_ptr_t'(pm[3:2]), sflo_amode_t'(pm[1:0]), 6'h02, ad, 6'h05};
        do @(negedge core_clk); while (opReady !== 1'b1);
        @(posedge core_clk);
        opValid <= 1'b0;
        repeat (n) @(negedge core_clk);
        chk({7'h0, opDone}, 8'h01);
    endtask
    task automatic end_of_test();
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, `SFLO_OFF_SP, 32'h0);
        chk(r[7:0], 8'hFF);
        apb(1'b1, 12'h018, 32'h0);
        chk({7'h0, perr}, 8'h01);
        setr(5'd16, 8'h81);
        for (int i = 0; i < 4; i++) begin
            op(so[i], 5'd16, 4'h0, 16'h0, 1);
            chk(statusFlags, sx[i][15:8]);
            getr(5'd16, sx[i][7:0]);
        end
        f = 8'h15;
        for (int i = 0; i < 8; i++) begin
            op(SFLO_OP_FLAG_SET, 5'(i), 4'h0, 16'h0, 1);
            chk(statusFlags, f | (8'h01 << i));
            op(SFLO_OP_FLAG_CLEAR, 5'(i), 4'h0, 16'h0, 1);
            f = f & ~(8'h01 << i);
            chk(statusFlags, f);
        end
        setr(5'd21, 8'h20);
        op(SFLO_OP_BIT_TO_TRANSFER_FLAG, 5'd21, 4'h0, 16'h0, 1);
        chk(statusFlags, 8'h40);
        setr(5'd18, 8'h81);
        op(SFLO_OP_TRANSFER_FLAG_TO_BIT, 5'd18, 4'h0, 16'h0, 1);
        getr(5'd18, 8'h85);
        for (int i = 0; i < 6; i++) begin
            setr(`SFLO_PTR_X + 5'(i), ptr[i]);
        end
        op(SFLO_OP_INDIRECT_LOAD, 5'd20, 4'h1, 16'h0, 2);
        getr(5'd20, 8'h5A);
        getr(`SFLO_PTR_X, 8'h01);
        op(SFLO_OP_INDIRECT_STORE, 5'd16, 4'h2, 16'h0, 2);
        chk(sflo_mem_model_i.dmem[9'h100], 8'hA0);
        getr(`SFLO_PTR_X, 8'h00);
        op(SFLO_OP_INDIRECT_LOAD, 5'd21, 4'h7, 16'h0, 2);
        getr(5'd21, 8'h58);
        op(SFLO_OP_INDIRECT_LOAD, 5'd22, 4'h6, 16'h0, 2);
        getr(5'd22, 8'hA5);
        getr(`SFLO_PTR_Y, 8'hFF);
        op(SFLO_OP_INDIRECT_STORE, 5'd21, 4'h5, 16'h0, 2);
        chk(sflo_mem_model_i.dmem[9'h0FF], 8'h58);
        getr(`SFLO_PTR_Y, 8'h00);
        op(SFLO_OP_INDIRECT_STORE, 5'd22, 4'hB, 16'h0, 2);
        chk(sflo_mem_model_i.dmem[9'h042], 8'hA5);
        op(SFLO_OP_DIRECT_STORE, 5'd20, 4'h0, 16'h0120, 2);
        chk(sflo_mem_model_i.dmem[9'h120], 8'h5A);
        op(SFLO_OP_DIRECT_LOAD, 5'd23, 4'h0, 16'h0100, 2);
        getr(5'd23, 8'hA0);
        op(SFLO_OP_PROGRAM_MEM_READ, 5'd24, 4'h9, 16'h0, 3);
        getr(5'd24, 8'hE5);
        getr(`SFLO_PTR_Z, 8'h41);
        op(SFLO_OP_PUSH, 5'd16, 4'h0, 16'h0, 2);
        chk(sflo_mem_model_i.dmem[9'h1FF], 8'hA0);
        op(SFLO_OP_POP, 5'd25, 4'h0, 16'h0, 2);
        getr(5'd25, 8'hA0);
        op(SFLO_OP_SWAP, 5'd16, 4'h0, 16'h0, 1);
        getr(5'd16, 8'h0A);
        op(SFLO_OP_PORT_IN, 5'd19, 4'h0, 16'h0, 1);
        getr(5'd19, 8'h3C);
        op(SFLO_OP_PORT_OUT, 5'd19, 4'h0, 16'h0, 1);
        chk({ioWe, 1'b0, ioWrAddr}, 8'h85);
        chk(ioWdata, 8'h3C);
        op(SFLO_OP_REGISTER_PAIR_COPY, 5'd2, 4'h0, 16'h8000, 1);
        getr(5'd2, 8'h85);
        getr(5'd3, 8'h3C);
        op(SFLO_OP_INDIRECT_LOAD, 5'd7, 4'h8, 16'h0, 2);
        getr(5'd7, 8'h1B);
        getr(`SFLO_PTR_Z, 8'h41);
        op(SFLO_OP_SLEEP, 5'd0, 4'h0, 16'h0, 1);
        chk({7'h0, sleepReq}, 8'h01);
        op(SFLO_OP_WATCHDOG_RESTART, 5'd0, 4'h0, 16'h0, 1);
        chk({6'h0, wdtRestart, sleepReq}, 8'h02);
        op(SFLO_OP_BREAK, 5'd0, 4'h0, 16'h0, 1);
        chk({6'h0, dbgBreak, wdtRestart}, 8'h02);
        end_of_test();
    end
endmodule
bind sflo_exec sflo_exec_asserts sflo_exec_asserts_i (.core_clk, .rst_n, .opValid, .opCmd, .opReady, .opDone,
    .memWe, .memRe, .progRe, .sleepReq, .wdtRestart, .ioWe, .dbgBreak, .statusFlags);
`default_nettype wire
